// File: src/dtfd_decoder.sv
// Drive terminal function decoder: terminal codes to drive commands, relay select.
// Assumes a 200 MHz core_clk, sync reset, plain register port, async pins.
`timescale 1ns/1ps
`default_nettype none
`include "dtfd_cfg.svh"
module dtfd_decoder import dtfd_pkg::*; #(
   parameter int TERMINALS = 4,
   parameter int TICK_CYC = `DTFD_TICK_CYC,
   parameter int COUNT_W = 16
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [TERMINALS-1:0] term_pins,
   input wire logic restart,
   input wire logic drive_running,
   input wire logic fault_active,
   input wire logic [15:0] output_frequency,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic run_cmd,
   output logic reverse_run,
   output logic inching_run,
   output logic inching_reverse,
   output logic stop_cmd,
   output logic emergency_halt,
   output logic [3:0] preset_index,
   output logic use_primary,
   output logic [1:0] accel_set,
   output logic [15:0] freq_command,
   output logic fault_clear,
   output logic loop_regulator,
   output logic sequence_program,
   output logic timer1_reached,
   output logic timer2_reached,
   output logic [COUNT_W-1:0] pulse_count,
   output logic pause_drive,
   output logic channel_y,
   output logic motor_thermistor,
   output logic relay_contact
);
   if (TERMINALS < 1 || TERMINALS > 4) begin : bad_terminals
      $error("TERMINALS must be 1 to 4");
   end
   if (TICK_CYC < 1 || COUNT_W < 1 || COUNT_W > 32) begin : bad_counts
      $error("TICK_CYC and COUNT_W out of range");
   end

   dtfd_term_if #(.TERMINALS(TERMINALS)) term ();

   dtfd_term_sync #(.TERMINALS(TERMINALS)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .pins(term_pins),
      .term(term)
   );

   dtfd_code_t term_code [TERMINALS];
   dtfd_code_t relay_sel;
   logic updown_persist;
   dtfd_freq_t base_frequency_setting;
   dtfd_freq_t start_freq;
   dtfd_freq_t thr1;
   dtfd_freq_t thr2;
   dtfd_freq_t min_freq;
   dtfd_freq_t max_freq;
   dtfd_freq_t jog_freq;
   logic [15:0] tmr1_set;
   logic [15:0] tmr2_set;
   dtfd_freq_t setpoint;
   logic [15:0] tmr1_cnt;
   logic [15:0] tmr2_cnt;
   logic [31:0] tick_cnt;
   logic tick;
   logic fault_rst_prev;
   logic seq_prev;
   logic pulse_prev;

   // True when any terminal coded f is active
   function automatic logic fn_on(input logic [TERMINALS-1:0] lvl,
                                  input dtfd_code_t codes [TERMINALS],
                                  input dtfd_code_t f);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < TERMINALS; i++) begin
         if (lvl[i] && codes[i] == f) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // Four selector bits, first to fourth, to preset number
   function automatic dtfd_preset_t preset_of(input logic [3:0] b);
      unique case (b)
         4'b1000: return 4'h1;
         4'b0100: return 4'h2;
         4'b0010: return 4'h3;
         4'b0001: return 4'h4;
         4'b1100: return 4'h5;
         4'b1010: return 4'h6;
         4'b1001: return 4'h7;
         4'b0110: return 4'h8;
         4'b0101: return 4'h9;
         4'b0011: return 4'hA;
         4'b1110: return 4'hB;
         4'b1101: return 4'hC;
         4'b1011: return 4'hD;
         4'b0111: return 4'hE;
         4'b1111: return 4'hF;
         4'b0000: return 4'h0;
      endcase
   endfunction

   // Reserved codes never match any decode below
   logic a_inch, a_inch_f, a_inch_r, a_dir, a_run, a_fwd, a_rev, a_stop;
   logic a_up, a_down, a_halt, a_frst, a_loop, a_seq, a_t1, a_t2;
   logic a_pulse, a_crst, a_pause, a_chan, a_therm, a_acc1, a_acc2;
   logic [3:0] a_pre;
   assign a_inch = fn_on(term.level, term_code, `DTFD_F_INCH);
   assign a_inch_f = fn_on(term.level, term_code, `DTFD_F_INCH_FWD);
   assign a_inch_r = fn_on(term.level, term_code, `DTFD_F_INCH_REV);
   assign a_dir = fn_on(term.level, term_code, `DTFD_F_DIR_SEL);
   assign a_run = fn_on(term.level, term_code, `DTFD_F_RUN);
   assign a_fwd = fn_on(term.level, term_code, `DTFD_F_FWD);
   assign a_rev = fn_on(term.level, term_code, `DTFD_F_REV);
   assign a_stop = fn_on(term.level, term_code, `DTFD_F_STOP);
   assign a_pre[3] = fn_on(term.level, term_code, `DTFD_F_PRESET1);
   assign a_pre[2] = fn_on(term.level, term_code, `DTFD_F_PRESET2);
   assign a_pre[1] = fn_on(term.level, term_code, `DTFD_F_PRESET3);
   assign a_pre[0] = fn_on(term.level, term_code, `DTFD_F_PRESET4);
   assign a_acc1 = fn_on(term.level, term_code, `DTFD_F_ACC1);
   assign a_acc2 = fn_on(term.level, term_code, `DTFD_F_ACC2);
   assign a_up = fn_on(term.level, term_code, `DTFD_F_UP);
   assign a_down = fn_on(term.level, term_code, `DTFD_F_DOWN);
   assign a_halt = fn_on(term.level, term_code, `DTFD_F_HALT);
   assign a_frst = fn_on(term.level, term_code, `DTFD_F_FAULT_RST);
   assign a_loop = fn_on(term.level, term_code, `DTFD_F_LOOP);
   assign a_seq = fn_on(term.level, term_code, `DTFD_F_SEQ);
   assign a_t1 = fn_on(term.level, term_code, `DTFD_F_TIMER1);
   assign a_t2 = fn_on(term.level, term_code, `DTFD_F_TIMER2);
   assign a_pulse = fn_on(term.level, term_code, `DTFD_F_PULSE);
   assign a_crst = fn_on(term.level, term_code, `DTFD_F_CNT_RST);
   assign a_pause = fn_on(term.level, term_code, `DTFD_F_PAUSE);
   assign a_chan = fn_on(term.level, term_code, `DTFD_F_CHAN_Y);
   assign a_therm = fn_on(term.level, term_code, `DTFD_F_THERM);

   // Register writes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < TERMINALS; i++) begin
            term_code[i] <= `DTFD_F_NONE;
         end
         relay_sel <= `DTFD_RST_RELAY;
         updown_persist <= 1'b0;
         base_frequency_setting <= `DTFD_RST_BASE;
         start_freq <= `DTFD_RST_START;
         thr1 <= `DTFD_RST_MAX;
         thr2 <= `DTFD_RST_MAX;
         min_freq <= `DTFD_RST_MIN;
         max_freq <= `DTFD_RST_MAX;
         jog_freq <= `DTFD_RST_JOG;
         tmr1_set <= `DTFD_RST_TMR;
         tmr2_set <= `DTFD_RST_TMR;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `DTFD_A_TERM_FUNC: begin
               for (int i = 0; i < TERMINALS; i++) begin
                  term_code[i] <= reg_wdata[8*i +: 6];
               end
            end
            `DTFD_A_RELAY: begin
               // Codes above 32 refused, old selection kept
               if (reg_wdata[5:0] <= `DTFD_R_MAX) begin
                  relay_sel <= reg_wdata[5:0];
               end
               updown_persist <= reg_wdata[`DTFD_PERSIST_BIT];
            end
            `DTFD_A_BASE: base_frequency_setting <= reg_wdata[15:0];
            `DTFD_A_START: start_freq <= reg_wdata[15:0];
            `DTFD_A_THR1: thr1 <= reg_wdata[15:0];
            `DTFD_A_THR2: thr2 <= reg_wdata[15:0];
            `DTFD_A_MIN: min_freq <= reg_wdata[15:0];
            `DTFD_A_MAX: max_freq <= reg_wdata[15:0];
            `DTFD_A_TMR1: tmr1_set <= reg_wdata[15:0];
            `DTFD_A_TMR2: tmr2_set <= reg_wdata[15:0];
            `DTFD_A_JOG: jog_freq <= reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // Register reads, data one cycle after the strobe, zero elsewhere
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `DTFD_A_TERM_FUNC: begin
               reg_rdata <= '0;
               for (int i = 0; i < TERMINALS; i++) begin
                  reg_rdata[8*i +: 6] <= term_code[i];
               end
            end
            `DTFD_A_RELAY: reg_rdata <= {23'h0, updown_persist, 2'h0, relay_sel};
            `DTFD_A_BASE: reg_rdata <= {16'h0, base_frequency_setting};
            `DTFD_A_START: reg_rdata <= {16'h0, start_freq};
            `DTFD_A_THR1: reg_rdata <= {16'h0, thr1};
            `DTFD_A_THR2: reg_rdata <= {16'h0, thr2};
            `DTFD_A_MIN: reg_rdata <= {16'h0, min_freq};
            `DTFD_A_MAX: reg_rdata <= {16'h0, max_freq};
            `DTFD_A_TMR1: reg_rdata <= {16'h0, tmr1_set};
            `DTFD_A_TMR2: reg_rdata <= {16'h0, tmr2_set};
            `DTFD_A_JOG: reg_rdata <= {16'h0, jog_freq};
            `DTFD_A_STATUS: reg_rdata <= {12'h0, accel_set, preset_index,
               relay_contact, motor_thermistor, channel_y, pause_drive,
               timer2_reached, timer1_reached, loop_regulator, use_primary,
               emergency_halt, stop_cmd, inching_reverse, inching_run,
               reverse_run, run_cmd};
            `DTFD_A_SETPT: reg_rdata <= {16'h0, setpoint};
            `DTFD_A_COUNT: reg_rdata <= 32'(pulse_count);
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // Run, stop and direction
   always_ff @(posedge core_clk) begin
      if (rst) begin
         run_cmd <= 1'b0;
         reverse_run <= 1'b0;
         stop_cmd <= 1'b0;
         emergency_halt <= 1'b0;
      end else begin
         stop_cmd <= a_stop;
         emergency_halt <= a_halt;
         // Stop and emergency override any run request
         run_cmd <= (a_run | a_fwd | a_rev) & ~a_stop & ~a_halt;
         reverse_run <= a_rev | a_dir;
      end
   end

   // Jog requests
   always_ff @(posedge core_clk) begin
      if (rst) begin
         inching_run <= 1'b0;
         inching_reverse <= 1'b0;
      end else begin
         inching_run <= (a_inch | a_inch_f | a_inch_r) & ~a_halt;
         inching_reverse <= a_inch_r;
      end
   end

   // Preset and ramp-time selection
   always_ff @(posedge core_clk) begin
      if (rst) begin
         preset_index <= 4'h0;
         use_primary <= 1'b1;
         accel_set <= 2'h0;
      end else begin
         preset_index <= preset_of(a_pre);
         use_primary <= (a_pre == 4'h0);
         accel_set <= {a_acc2, a_acc1};
      end
   end

   // Ramp tick shared by up/down and timers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
         tick_cnt <= '0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
         tick <= 1'b0;
      end
   end

   // Up/down setpoint; both active cancel out
   always_ff @(posedge core_clk) begin
      if (rst) begin
         setpoint <= `DTFD_RST_BASE;
      end else if (reg_wr && reg_addr == `DTFD_A_BASE) begin
         setpoint <= reg_wdata[15:0];
      end else if (restart && !updown_persist) begin
         setpoint <= base_frequency_setting;
      end else if (tick && a_up && !a_down && setpoint < max_freq) begin
         setpoint <= setpoint + 16'h1;
      end else if (tick && a_down && !a_up && setpoint > min_freq) begin
         setpoint <= setpoint - 16'h1;
      end
   end

   // Jog frequency takes priority over the normal setpoint
   always_ff @(posedge core_clk) begin
      if (rst) begin
         freq_command <= `DTFD_RST_BASE;
      end else begin
         freq_command <= (a_inch | a_inch_f | a_inch_r) ? jog_freq : setpoint;
      end
   end

   // Fault clear and sequence start are one-cycle pulses on activation
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fault_rst_prev <= 1'b0;
         seq_prev <= 1'b0;
         fault_clear <= 1'b0;
         sequence_program <= 1'b0;
      end else begin
         fault_rst_prev <= a_frst;
         seq_prev <= a_seq;
         fault_clear <= a_frst & ~fault_rst_prev;
         sequence_program <= a_seq & ~seq_prev;
      end
   end

   // Level functions
   always_ff @(posedge core_clk) begin
      if (rst) begin
         loop_regulator <= 1'b0;
         pause_drive <= 1'b0;
         channel_y <= 1'b0;
         motor_thermistor <= 1'b0;
      end else begin
         loop_regulator <= a_loop;
         pause_drive <= a_pause;
         channel_y <= a_chan;
         motor_thermistor <= a_therm;
      end
   end

   // Timers run only while their contact is on, cleared when it drops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tmr1_cnt <= '0;
         tmr2_cnt <= '0;
         timer1_reached <= 1'b0;
         timer2_reached <= 1'b0;
      end else begin
         if (!a_t1) begin
            tmr1_cnt <= '0;
         end else if (tick && tmr1_cnt < tmr1_set) begin
            tmr1_cnt <= tmr1_cnt + 16'h1;
         end
         if (!a_t2) begin
            tmr2_cnt <= '0;
         end else if (tick && tmr2_cnt < tmr2_set) begin
            tmr2_cnt <= tmr2_cnt + 16'h1;
         end
         timer1_reached <= a_t1 && tmr1_cnt >= tmr1_set;
         timer2_reached <= a_t2 && tmr2_cnt >= tmr2_set;
      end
   end

   // Pulse counter; synchronised edges resolve far above 250 Hz
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pulse_prev <= 1'b0;
         pulse_count <= '0;
      end else begin
         pulse_prev <= a_pulse;
         if (a_crst) begin
            pulse_count <= '0;
         end else if (a_pulse && !pulse_prev) begin
            pulse_count <= pulse_count + COUNT_W'(1);
         end
      end
   end

   // Relay condition; codes 7 to 32 not served here, contact open
   always_ff @(posedge core_clk) begin
      if (rst) begin
         relay_contact <= 1'b0;
      end else begin
         unique case (relay_sel)
            `DTFD_R_NONE: relay_contact <= 1'b0;
            `DTFD_R_RUN: relay_contact <= drive_running;
            `DTFD_R_FREQ_HIT: relay_contact <= output_frequency == freq_command;
            `DTFD_R_FAULT: relay_contact <= fault_active;
            `DTFD_R_ZERO: relay_contact <= output_frequency < start_freq;
            `DTFD_R_THR1: relay_contact <= output_frequency >= thr1;
            `DTFD_R_THR2: relay_contact <= output_frequency >= thr2;
            default: relay_contact <= 1'b0;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: src/dtfd_cfg.svh
// Constants of the terminal function decoder: codes, offsets, resets, timing.
// Assumes inclusion by bare name from every file that needs them.
`ifndef DTFD_CFG_SVH
`define DTFD_CFG_SVH

// Terminal function codes
`define DTFD_F_NONE 6'h00
`define DTFD_F_INCH 6'h01
`define DTFD_F_INCH_FWD 6'h02
`define DTFD_F_INCH_REV 6'h03
`define DTFD_F_DIR_SEL 6'h04
`define DTFD_F_RUN 6'h05
`define DTFD_F_FWD 6'h06
`define DTFD_F_REV 6'h07
`define DTFD_F_STOP 6'h08
`define DTFD_F_PRESET1 6'h09
`define DTFD_F_PRESET2 6'h0A
`define DTFD_F_PRESET3 6'h0B
`define DTFD_F_PRESET4 6'h0C
`define DTFD_F_ACC1 6'h0D
`define DTFD_F_ACC2 6'h0E
`define DTFD_F_UP 6'h0F
`define DTFD_F_DOWN 6'h10
`define DTFD_F_HALT 6'h11
`define DTFD_F_FAULT_RST 6'h12
`define DTFD_F_LOOP 6'h13
`define DTFD_F_SEQ 6'h14
`define DTFD_F_TIMER1 6'h15
`define DTFD_F_TIMER2 6'h16
`define DTFD_F_PULSE 6'h17
`define DTFD_F_CNT_RST 6'h18
`define DTFD_F_PAUSE 6'h19
`define DTFD_F_CHAN_Y 6'h1A
`define DTFD_F_THERM 6'h20

// Relay condition codes
`define DTFD_R_NONE 6'h00
`define DTFD_R_RUN 6'h01
`define DTFD_R_FREQ_HIT 6'h02
`define DTFD_R_FAULT 6'h03
`define DTFD_R_ZERO 6'h04
`define DTFD_R_THR1 6'h05
`define DTFD_R_THR2 6'h06
`define DTFD_R_MAX 6'h20

// Register byte addresses
`define DTFD_A_TERM_FUNC 8'h00
`define DTFD_A_RELAY 8'h04
`define DTFD_A_BASE 8'h08
`define DTFD_A_START 8'h0C
`define DTFD_A_THR1 8'h10
`define DTFD_A_THR2 8'h14
`define DTFD_A_MIN 8'h18
`define DTFD_A_MAX 8'h1C
`define DTFD_A_TMR1 8'h20
`define DTFD_A_TMR2 8'h24
`define DTFD_A_JOG 8'h28
`define DTFD_A_STATUS 8'h2C
`define DTFD_A_SETPT 8'h30
`define DTFD_A_COUNT 8'h34

// Reset values, frequencies in 0.01 Hz
`define DTFD_RST_RELAY 6'h03
`define DTFD_RST_JOG 16'h01F4
`define DTFD_RST_BASE 16'h1388
`define DTFD_RST_MAX 16'h1388
`define DTFD_RST_MIN 16'h0000
`define DTFD_RST_START 16'h0032
`define DTFD_RST_TMR 16'h03E8
`define DTFD_PERSIST_BIT 8

// Timing: clock period and ramp/timer tick, in ns
`define DTFD_CLK_NS 5
`define DTFD_TICK_NS 1000000
`define DTFD_TICK_CYC (`DTFD_TICK_NS / `DTFD_CLK_NS)
`define DTFD_PULSE_MAX_HZ 250

`endif

// File: src/dtfd_pkg.sv
// Types of the terminal function decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package dtfd_pkg;
   typedef logic [5:0] dtfd_code_t;
   typedef logic [15:0] dtfd_freq_t;
   typedef logic [1:0] dtfd_acc_t;
   typedef logic [3:0] dtfd_preset_t;
endpackage

// File: src/dtfd_term_if.sv
// Carrier of synchronised terminal levels between decoder modules.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
`default_nettype none
interface dtfd_term_if #(parameter int TERMINALS = 4);
   logic [TERMINALS-1:0] level;
   modport src (output level);
   modport dst (input level);
endinterface
`default_nettype wire

// File: src/dtfd_term_sync.sv
// Three-stage synchroniser for the terminal pins.
// Assumes pins are asynchronous to core_clk; feeds the decoder via the carrier.
`timescale 1ns/1ps
`default_nettype none
module dtfd_term_sync #(
   parameter int TERMINALS = 4
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [TERMINALS-1:0] pins,
   dtfd_term_if.src term
);
   logic [TERMINALS-1:0] stage1;
   logic [TERMINALS-1:0] stage2;
   logic [TERMINALS-1:0] stage3;

   // First stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= pins;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // A level counts once stages two and three agree; filters one-cycle glitches
   always_ff @(posedge core_clk) begin
      if (rst) begin
         term.level <= '0;
      end else begin
         for (int i = 0; i < TERMINALS; i++) begin
            if (stage2[i] == stage3[i]) begin
               term.level[i] <= stage3[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/dtfd_decoder_asserts.sv
// Output relations of the terminal decoder at its top ports.
// Assumes binding into dtfd_decoder, one core_clk domain.
`timescale 1ns/1ps
`default_nettype none
module dtfd_decoder_asserts #(
   parameter int COUNT_W = 16
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic run_cmd,
   input wire logic stop_cmd,
   input wire logic emergency_halt,
   input wire logic inching_run,
   input wire logic inching_reverse,
   input wire logic [3:0] preset_index,
   input wire logic use_primary,
   input wire logic fault_clear,
   input wire logic sequence_program,
   input wire logic [COUNT_W-1:0] pulse_count
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_primary_no_preset: assert property (use_primary == (preset_index == 4'h0))
      else $error("primary flag disagrees with preset index");
   a_halt_blocks_run: assert property (emergency_halt |-> !run_cmd)
      else $error("run while halted");
   a_stop_blocks_run: assert property (stop_cmd |-> !run_cmd)
      else $error("run while stopped");
   a_halt_blocks_inch: assert property (emergency_halt |-> !inching_run)
      else $error("inching while halted");
   a_inch_rev_run: assert property (inching_reverse |-> inching_run || emergency_halt)
      else $error("inching reverse without inching");
   a_clear_one_cycle: assert property ($rose(fault_clear) |=> !fault_clear)
      else $error("fault clear longer than one cycle");
   a_seq_one_cycle: assert property (sequence_program |=> !sequence_program)
      else $error("sequence start longer than one cycle");
   // Pins hold eight cycles, so one edge gives one step
   a_count_single_step: assert property ($changed(pulse_count) && pulse_count != 0
      |-> pulse_count == $past(pulse_count) + 1'h1 ##1 $stable(pulse_count))
      else $error("pulse count jumped");
endmodule
bind dtfd_decoder dtfd_decoder_asserts #(.COUNT_W(COUNT_W)) chk_u (.core_clk, .rst,
   .run_cmd, .stop_cmd, .emergency_halt, .inching_run, .inching_reverse,
   .preset_index, .use_primary, .fault_clear, .sequence_program, .pulse_count);
`default_nettype wire

// File: tb/dtfd_pins_model.sv
// External contacts driving the terminal pins.
// Assumes the bench holds each requested level for several cycles.
`timescale 1ns/1ps
`default_nettype none
module dtfd_pins_model (
   input wire logic core_clk,
   input wire logic [3:0] want,
   output logic [3:0] pins
);
   // Contacts bounce-free; pulse spacing shortened, no rate filter seen
   always_ff @(posedge core_clk) begin
      pins <= want;
   end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Bench of the terminal decoder: register and pin sequences.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dtfd_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, restart = 1'b0;
   logic drive_running = 1'b0, fault_active = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] output_frequency = 16'h0000;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic [3:0] want = 4'h0, pins, preset_index;
   logic run_cmd, reverse_run, inching_run, inching_reverse, stop_cmd, emergency_halt;
   logic use_primary, loop_regulator, timer1_reached, timer2_reached, pause_drive;
   logic channel_y, motor_thermistor, relay_contact, fault_clear, sequence_program;
   int n_clr = 0, n_seq = 0;
   logic [1:0] accel_set;
   logic [15:0] freq_command, pulse_count;
   logic [3:0] pidx [16] = '{0, 1, 2, 5, 3, 6, 8, 11, 4, 7, 9, 12, 10, 13, 14, 15};
   logic [6:0] rexp = 7'h3A;
   int err_total = 0, n_tests = 0;
   initial forever #2.5 core_clk = ~core_clk;
   dtfd_pins_model pm_u (.core_clk, .want, .pins);
   dtfd_decoder #(.TICK_CYC(4)) dut_u (.core_clk, .rst, .term_pins(pins), .restart,
      .drive_running, .fault_active, .output_frequency, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .run_cmd, .reverse_run, .inching_run, .inching_reverse,
      .stop_cmd, .emergency_halt, .preset_index, .use_primary, .accel_set, .freq_command,
      .fault_clear, .loop_regulator, .sequence_program, .timer1_reached,
      .timer2_reached, .pulse_count, .pause_drive, .channel_y, .motor_thermistor,
      .relay_contact);
   // One-cycle pulses are counted as they stand
   always @(posedge core_clk) begin
      if (fault_clear) n_clr++;
      if (sequence_program) n_seq++;
   end
   task wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge core_clk);
   endtask
   // Eight cycles covers the four-edge synchroniser path, the decoder output flop and the model flop
   task st(input logic [3:0] v);
      want <= v;
      repeat (8) @(posedge core_clk);
      #1;
   endtask
   task rs;
      restart <= 1'b1;
      @(posedge core_clk);
      restart <= 1'b0;
      @(posedge core_clk);
   endtask
   task cmp(input string n, input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task give_verdict;
      $display("mismatches %0d comparisons %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      give_verdict;
   end
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(8'h04);
      cmp("relay_sel", d, 32'h3);
      rd(8'h28);
      cmp("inch_freq", d, 32'h1F4);
      rd(8'h3C);
      cmp("unmapped", d, 32'h0);
      wr(8'h00, 32'h00000406);
      st(4'h1);
      cmp("run_dir", {run_cmd, reverse_run}, 2'h2);
      st(4'h3);
      cmp("run_dir", {run_cmd, reverse_run}, 2'h3);
      st(4'h0);
      cmp("run_dir", {run_cmd, reverse_run}, 2'h0);
      wr(8'h00, 32'h0C0B0A09);
      for (int p = 0; p < 16; p++) begin
         st(p[3:0]);
         cmp("preset", {use_primary, preset_index}, {p == 0, pidx[p]});
      end
      wr(8'h00, 32'h00000E0D);
      for (int p = 0; p < 4; p++) begin
         st(p[3:0]);
         cmp("accel", accel_set, p[1:0]);
      end
      wr(8'h00, 32'h01110805);
      st(4'h1);
      cmp("run", run_cmd, 1'h1);
      st(4'h3);
      cmp("stop", {run_cmd, stop_cmd}, 2'h1);
      st(4'h5);
      cmp("halt", {run_cmd, emergency_halt}, 2'h1);
      st(4'h8);
      cmp("inch", {inching_run, freq_command}, 17'h101F4);
      st(4'hC);
      cmp("inch_halt", inching_run, 1'h0);
      wr(8'h00, 32'h00030207);
      st(4'h1);
      cmp("reverse", {run_cmd, reverse_run}, 2'h3);
      st(4'h2);
      cmp("inch_dir", {inching_run, inching_reverse}, 2'h2);
      st(4'h4);
      cmp("inch_dir", {inching_run, inching_reverse}, 2'h3);
      wr(8'h00, 32'h201A1913);
      st(4'hF);
      cmp("levels", {loop_regulator, pause_drive, channel_y, motor_thermistor}, 4'hF);
      wr(8'h00, 32'h3B211F1B);
      st(4'hF);
      rd(8'h2C);
      cmp("status", d, 32'h40);
      // Pins low first, so the counter sees a clean first edge
      st(4'h0);
      wr(8'h00, 32'h14121817);
      for (int i = 0; i < 5; i++) begin
         st(4'h1);
         st(4'h0);
      end
      cmp("count", pulse_count, 16'h5);
      cmp("pulses", {n_clr[1:0], n_seq[1:0]}, 4'h0);
      st(4'hE);
      cmp("count", pulse_count, 16'h0);
      cmp("pulses", {n_clr[1:0], n_seq[1:0]}, 4'h5);
      wr(8'h00, 32'h0000100F);
      wr(8'h08, 32'h100);
      wr(8'h1C, 32'h102);
      wr(8'h18, 32'hFE);
      st(4'h1);
      repeat (40) @(posedge core_clk);
      rd(8'h30);
      cmp("setpoint", d, 32'h102);
      st(4'h2);
      repeat (40) @(posedge core_clk);
      rd(8'h30);
      cmp("setpoint", d, 32'hFE);
      st(4'h0);
      rs;
      rd(8'h30);
      cmp("setpoint", d, 32'h100);
      wr(8'h04, 32'h103);
      st(4'h1);
      repeat (40) @(posedge core_clk);
      st(4'h0);
      rs;
      rd(8'h30);
      cmp("setpoint", d, 32'h102);
      wr(8'h00, 32'h00001615);
      wr(8'h20, 32'h2);
      wr(8'h24, 32'h3);
      st(4'h1);
      repeat (40) @(posedge core_clk);
      cmp("timers", {timer1_reached, timer2_reached}, 2'h2);
      st(4'h2);
      repeat (40) @(posedge core_clk);
      cmp("timers", {timer1_reached, timer2_reached}, 2'h1);
      st(4'h0);
      cmp("timers", {timer1_reached, timer2_reached}, 2'h0);
      drive_running <= 1'b1;
      fault_active <= 1'b1;
      output_frequency <= 16'h0010;
      wr(8'h10, 32'h10);
      for (int c = 0; c < 7; c++) begin
         wr(8'h04, c);
         st(4'h0);
         cmp("relay", relay_contact, rexp[c]);
      end
      wr(8'h04, 32'h1);
      wr(8'h04, 32'h28);
      rd(8'h04);
      cmp("relay_sel", d, 32'h1);
      give_verdict;
   end
endmodule
`default_nettype wire
